// ==== rtl/zcd_defines.vh ====
// Purpose: register offsets, field positions and reset values of the zero-cross block
// Assumes: included by the zero-cross top design file and by its testbench
// Notes: byte addresses on a 32-bit AXI4-Lite register port
`ifndef ZCD_DEFINES_VH
`define ZCD_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ZCD_OFF_CTRL 4'h0
`define ZCD_OFF_IEN 4'h4
`define ZCD_OFF_IFLG 4'h8
`define ZCD_OFF_INTC 4'hC

// ****************************************************************
// control register fields
// ****************************************************************
`define ZCD_CTRL_EN 7
`define ZCD_CTRL_OUT 5
`define ZCD_CTRL_POL 4
`define ZCD_CTRL_RISE 1
`define ZCD_CTRL_FALL 0

// ****************************************************************
// interrupt enable and flag field (bit 6 of both)
// ****************************************************************
`define ZCD_IRQ_BIT 6

// ****************************************************************
// system interrupt control fields
// ****************************************************************
`define ZCD_INTC_GLOBAL 7
`define ZCD_INTC_PERIPH 6

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define ZCD_CTRL_RST 8'h00
`define ZCD_RESP_OKAY 2'h0
`define ZCD_RESP_SLVERR 2'h2

`endif

// ==== rtl/zcd_sync3.v ====
// Purpose: three-stage synchroniser with agreement filter for one asynchronous level
// Assumes: single clock MCLK domain, synchronous active-high reset
// Notes: output changes only once stage two and stage three agree

module zcd_sync3
(
   // clock and reset
   input wire clk,
   input wire rst,
   // asynchronous level in, filtered level out
   input wire async_in,
   output reg level_q
);

   reg meta_q;
   reg s2_q;
   reg s3_q;

   // ****************************************************************
   // sampling chain
   // ****************************************************************
   // first stage is read by the second stage only
   always @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         s2_q <= meta_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level_q <= s3_q; // a change counts once both stages agree
         end
      end
   end

endmodule // zcd_sync3

// ==== rtl/zcd_top.v ====
// Purpose: digital side of a zero-cross detector with AXI4-Lite registers and interrupt
// Assumes: comparator decision COMP_SINK arrives asynchronously; MCLK 10 MHz
// Notes: registers at 0x0 control, 0x4 irq enable, 0x8 irq flag, 0xC system irq gates
//        the flag clears only by a write of 0; reads have no side effect
//        only byte lane 0 of WSTRB is honoured; a write without it is answered, not applied
//        a change of the invert bit alone counts as an edge, enabled detector or not

module zcd_top
(
   // clock and reset
   input wire MCLK,
   input wire RST,
   // analog comparator and pin control
   input wire COMP_SINK,
   input wire DETECTOR_OFF_AT_POWERON,
   output reg PIN_CURRENT_MODE,
   output reg PIN_SINK_ACTIVE,
   output reg ZERO_CROSS_OUT,
   // interrupt
   output reg IRQ,
   // axi4-lite write address
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   // axi4-lite write data
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   // axi4-lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // axi4-lite read address
   input wire [3:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   // axi4-lite read data
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);

`include "zcd_defines.vh"

   // control state
   reg detector_enable_q;
   reg output_invert_q;
   reg rising_edge_enable_q;
   reg falling_edge_enable_q;
   reg zero_cross_irq_enable_q;
   reg peripheral_irq_gate_q;
   reg global_irq_gate_q;
   reg zero_cross_flag_q;
   reg zero_cross_flag_d;
   reg logic_out_prev_q;
   reg strap_taken_q;
   // write channel capture
   reg aw_have_q;
   reg w_have_q;
   reg [3:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   // combinational helpers
   wire sink_sync;
   wire logic_out;
   wire rise_hit;
   wire fall_hit;
   wire wr_fire;
   wire wr_lane0;
   wire clear_flag;
   wire rd_known;
   // read side
   reg [31:0] rd_word;

   // true when the offset matches one of the four implemented words
   function mapped;
      input [3:0] addr;
      begin
         mapped = (addr[1:0] == 2'h0);
      end
   endfunction

   // ****************************************************************
   // comparator input and logic output
   // ****************************************************************
   // asynchronous comparator level is filtered before any use
   zcd_sync3 u_sync
   (
      .clk(MCLK),
      .rst(RST),
      .async_in(COMP_SINK),
      .level_q(sink_sync)
   );

   // polarity applies whether or not the detector is enabled
   assign logic_out = sink_sync ^ output_invert_q;

   // edges on the adjusted output, so polarity decides which is rising
   // a change of invert alone also makes an edge here, enabled detector or not
   assign rise_hit = logic_out & ~logic_out_prev_q & rising_edge_enable_q;
   assign fall_hit = ~logic_out & logic_out_prev_q & falling_edge_enable_q;

   // ****************************************************************
   // register write decode
   // ****************************************************************
   // a write commits once both halves are held and no answer is pending
   assign wr_fire = aw_have_q & w_have_q & ~S_AXI_BVALID;
   // only lane 0 carries bits; without it the write is answered but not applied
   assign wr_lane0 = wr_fire & w_strb_q[0] & mapped(aw_addr_q);
   // writing 1 to the flag does nothing, so software cannot fake an event
   assign clear_flag = wr_lane0 & (aw_addr_q == `ZCD_OFF_IFLG)
                       & ~w_data_q[`ZCD_IRQ_BIT];

   // next flag value: hardware set takes priority over software clear
   // order matters: the set below overrides the clear above
   always @*
   begin
      zero_cross_flag_d = zero_cross_flag_q;
      if (clear_flag)
      begin
         zero_cross_flag_d = 1'b0;
      end
      if (rise_hit | fall_hit)
      begin
         zero_cross_flag_d = 1'b1;
      end
   end

   // ****************************************************************
   // detector state and registers
   // ****************************************************************
   // no sleep gating exists here: the block keeps working on MCLK
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         detector_enable_q <= 1'b0;
         output_invert_q <= 1'b0;
         rising_edge_enable_q <= 1'b0;
         falling_edge_enable_q <= 1'b0;
         zero_cross_irq_enable_q <= 1'b0;
         peripheral_irq_gate_q <= 1'b0;
         global_irq_gate_q <= 1'b0;
         zero_cross_flag_q <= 1'b0;
         logic_out_prev_q <= 1'b0;
         strap_taken_q <= 1'b0;
      end
      else
      begin
         // previous output resets to the reset level of logic_out, so no false edge
         logic_out_prev_q <= logic_out;
         zero_cross_flag_q <= zero_cross_flag_d;
         // strap is sampled by a clocked step after release, never by reset itself
         if (!strap_taken_q)
         begin
            strap_taken_q <= 1'b1;
            detector_enable_q <= ~DETECTOR_OFF_AT_POWERON;
         end
         // writes land at the edge that raises the write answer
         if (wr_lane0)
         begin
            case (aw_addr_q)
               `ZCD_OFF_CTRL:
               begin
                  detector_enable_q <= w_data_q[`ZCD_CTRL_EN];
                  output_invert_q <= w_data_q[`ZCD_CTRL_POL];
                  rising_edge_enable_q <= w_data_q[`ZCD_CTRL_RISE];
                  falling_edge_enable_q <= w_data_q[`ZCD_CTRL_FALL];
               end
               `ZCD_OFF_IEN:
               begin
                  zero_cross_irq_enable_q <= w_data_q[`ZCD_IRQ_BIT];
               end
               `ZCD_OFF_INTC:
               begin
                  global_irq_gate_q <= w_data_q[`ZCD_INTC_GLOBAL];
                  peripheral_irq_gate_q <= w_data_q[`ZCD_INTC_PERIPH];
               end
               default:
               begin
                  global_irq_gate_q <= global_irq_gate_q;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // pin control and interrupt outputs
   // ****************************************************************
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         PIN_CURRENT_MODE <= 1'b0;
         PIN_SINK_ACTIVE <= 1'b0;
         ZERO_CROSS_OUT <= 1'b0;
         IRQ <= 1'b0;
      end
      else
      begin
         PIN_CURRENT_MODE <= detector_enable_q;
         // sink flag stays low while disabled: the pin is then under normal control
         // sink when the pin sits above the reference, source otherwise
         PIN_SINK_ACTIVE <= detector_enable_q & sink_sync;
         ZERO_CROSS_OUT <= logic_out;
         // all three gates needed; the pull-up stays software's job
         IRQ <= zero_cross_flag_d & zero_cross_irq_enable_q
                & peripheral_irq_gate_q & global_irq_gate_q;
      end
   end

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   // address and data are taken in either order; response after both
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `ZCD_RESP_OKAY;
      end
      else
      begin
         // one-cycle ready pulses; a held half blocks a second capture
         S_AXI_AWREADY <= ~aw_have_q & ~S_AXI_AWREADY & S_AXI_AWVALID;
         S_AXI_WREADY <= ~w_have_q & ~S_AXI_WREADY & S_AXI_WVALID;
         if (S_AXI_AWVALID & S_AXI_AWREADY)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY)
         begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         // a refused offset still gets its answer, as SLVERR
         if (wr_fire)
         begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= mapped(aw_addr_q) ? `ZCD_RESP_OKAY : `ZCD_RESP_SLVERR;
         end
         else if (S_AXI_BVALID & S_AXI_BREADY)
         begin
            S_AXI_BVALID <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   assign rd_known = mapped(S_AXI_ARADDR);

   // read word assembly; unused bits and unmapped offsets read as zero
   always @*
   begin
      rd_word = 32'h00000000;
      case (S_AXI_ARADDR)
         `ZCD_OFF_CTRL:
         begin
            rd_word[`ZCD_CTRL_EN] = detector_enable_q;
            rd_word[`ZCD_CTRL_OUT] = logic_out;
            rd_word[`ZCD_CTRL_POL] = output_invert_q;
            rd_word[`ZCD_CTRL_RISE] = rising_edge_enable_q;
            rd_word[`ZCD_CTRL_FALL] = falling_edge_enable_q;
         end
         `ZCD_OFF_IEN:
         begin
            rd_word[`ZCD_IRQ_BIT] = zero_cross_irq_enable_q;
         end
         `ZCD_OFF_IFLG:
         begin
            rd_word[`ZCD_IRQ_BIT] = zero_cross_flag_q;
         end
         `ZCD_OFF_INTC:
         begin
            rd_word[`ZCD_INTC_GLOBAL] = global_irq_gate_q;
            rd_word[`ZCD_INTC_PERIPH] = peripheral_irq_gate_q;
         end
         default:
         begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // reads have no side effect; the flag only clears by a write of 0
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= `ZCD_RESP_OKAY;
      end
      else
      begin
         // no new address while an answer stands: one read at a time
         S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
         if (S_AXI_ARVALID & S_AXI_ARREADY)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_known ? `ZCD_RESP_OKAY : `ZCD_RESP_SLVERR;
         end
         else if (S_AXI_RVALID & S_AXI_RREADY)
         begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule // zcd_top

// ==== sim/tb_zero_cross_logic_output_irq.sv ====
// Purpose: register-level tests of the zero-cross block
// Assumes: 10 MHz MCLK, AXI4-Lite master changes signals after rising edges
// Notes: fixed waits cover the synchroniser latency of the detector
`include "zcd_defines.vh"
module tb_zero_cross_logic_output_irq;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'b0, RST = 1'b1, wave_hi = 1'b0, strap = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp, resp;
   wire logic comp;
   logic mode, sink, zc_out, irq, awready, wready, bvalid, arready, rvalid;
   int checks = 0, error_cnt = 0;
   always #50 MCLK = ~MCLK;
   zcloi_comp_model CMP (.wave_hi(wave_hi), .comp_sink(comp));
   zcd_top DUT (.MCLK(MCLK), .RST(RST), .COMP_SINK(comp), .DETECTOR_OFF_AT_POWERON(strap),
      .PIN_CURRENT_MODE(mode), .PIN_SINK_ACTIVE(sink), .ZERO_CROSS_OUT(zc_out), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   // ************************************************
   // access tasks
   // ************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge MCLK);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 40) error_cnt++;
      resp = bresp;
      bready <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge MCLK);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 40) error_cnt++;
      chk(nm, rdata, exp);
      rready <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic wave(input logic v);
      wave_hi <= v;
      repeat (10) @(posedge MCLK);
   endtask
   task give_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ************************************************
   // tests
   // ************************************************
   initial
   begin
      repeat (20) @(posedge MCLK);
      RST <= 1'b0;
      repeat (2) @(posedge MCLK);
      rd_chk("ctrl", `ZCD_OFF_CTRL, 32'h80);
      chk("rresp", rresp, `ZCD_RESP_OKAY);
      rd_chk("ien", `ZCD_OFF_IEN, 32'h0);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h0);
      rd_chk("intc", `ZCD_OFF_INTC, 32'h0);
      wave(1'b1);
      chk("sink", sink, 1'b1);
      chk("mode", mode, 1'b1);
      rd_chk("ctrl", `ZCD_OFF_CTRL, 32'hA0);
      $display("test reset and sink done");
      wr(`ZCD_OFF_CTRL, 32'h00);
      chk("mode", mode, 1'b0);
      chk("sink", sink, 1'b0);
      rd_chk("ctrl", `ZCD_OFF_CTRL, 32'h20);
      wr(`ZCD_OFF_CTRL, 32'h10);
      chk("out", zc_out, 1'b0);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h0);
      $display("test polarity done");
      wr(`ZCD_OFF_CTRL, 32'h92);
      wave(1'b0);
      chk("out", zc_out, 1'b1);
      chk("irq", irq, 1'b0);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h40);
      wr(`ZCD_OFF_IFLG, 32'h0);
      wave(1'b1);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h0);
      wr(`ZCD_OFF_CTRL, 32'h91);
      wave(1'b0);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h0);
      wave(1'b1);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h40);
      wr(`ZCD_OFF_IFLG, 32'h0);
      wr(`ZCD_OFF_CTRL, 32'h02);
      repeat (3) @(posedge MCLK);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h40);
      $display("test edges done");
      wr(`ZCD_OFF_IEN, 32'h40);
      chk("irq", irq, 1'b0);
      wr(`ZCD_OFF_INTC, 32'h40);
      chk("irq", irq, 1'b0);
      wr(`ZCD_OFF_INTC, 32'h80);
      chk("irq", irq, 1'b0);
      wr(`ZCD_OFF_INTC, 32'hC0);
      chk("irq", irq, 1'b1);
      wr(`ZCD_OFF_IFLG, 32'h40);
      chk("irq", irq, 1'b1);
      wr(`ZCD_OFF_IFLG, 32'h0);
      chk("irq", irq, 1'b0);
      $display("test interrupt done");
      wstrb <= 4'h0;
      wr(`ZCD_OFF_CTRL, 32'h00);
      chk("bresp", resp, `ZCD_RESP_OKAY);
      wstrb <= 4'hF;
      wr(4'h1, 32'h0);
      chk("bresp", resp, `ZCD_RESP_SLVERR);
      rd_chk("odd", 4'h2, 32'h0);
      chk("rresp", rresp, `ZCD_RESP_SLVERR);
      rd_chk("ctrl", `ZCD_OFF_CTRL, 32'h22);
      wr(`ZCD_OFF_CTRL, 32'h12);
      // analog edge timed to meet the clearing write in one cycle
      wave_hi <= 1'b0;
      repeat (2) @(posedge MCLK);
      wr(`ZCD_OFF_IFLG, 32'h0);
      rd_chk("iflg", `ZCD_OFF_IFLG, 32'h40);
      chk("irq", irq, 1'b1);
      $display("test set priority done");
      strap <= 1'b1;
      wave_hi <= 1'b1;
      RST <= 1'b1;
      repeat (20) @(posedge MCLK);
      RST <= 1'b0;
      repeat (10) @(posedge MCLK);
      rd_chk("ctrl", `ZCD_OFF_CTRL, 32'h20);
      $display("test refusal and strap done");
      give_verdict();
   end
   initial
   begin
      repeat (6000) @(posedge MCLK);
      error_cnt++;
      give_verdict();
   end
endmodule // tb_zero_cross_logic_output_irq
bind zcd_top zcloi_checker CHK (.MCLK(MCLK), .RST(RST), .IRQ(IRQ),
   .ZERO_CROSS_OUT(ZERO_CROSS_OUT), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY));

// ==== sim/zcloi_checker.sv ====
// Purpose: port-level checks of the zero-cross block
// Assumes: one clock MCLK, synchronous active-high RST
// Notes: bound to zcd_top from the bench top file
module zcloi_checker
(
   // clock, reset and detector outputs
   input wire logic MCLK,
   input wire logic RST,
   input wire logic IRQ,
   input wire logic ZERO_CROSS_OUT,
   // register bus
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (RST);
   // ************************************************
   // handshake steps
   // ************************************************
   sequence aw_hs;
      S_AXI_AWVALID && S_AXI_AWREADY;
   endsequence
   sequence ar_hs;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   // ************************************************
   // bus answers
   // ************************************************
   bresp_taken_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write answer stayed after taken");
   rresp_taken_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read answer stayed after taken");
   rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   awready_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("write address ready longer than one cycle");
   arready_pulse_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY)
      else $error("read address ready longer than one cycle");
   read_answer_a: assert property (ar_hs |-> ##[0:2] S_AXI_RVALID)
      else $error("read answer late");
   unaligned_resp_a: assert property (aw_hs ##0 S_AXI_AWADDR[1:0] != 2'h0
      |-> ##[1:4] S_AXI_BVALID && S_AXI_BRESP == 2'h2) else $error("unaligned write not refused");
   reset_out_a: assert property ($fell(RST) |-> !IRQ && !S_AXI_BVALID && !S_AXI_RVALID)
      else $error("outputs active after reset");
   // the flag is sticky: irq can only drop at a register update
   irq_sticky_a: assert property ($fell(IRQ) |-> $rose(S_AXI_BVALID))
      else $error("interrupt dropped without a write");
   // synchroniser filter: no single-cycle glitch on the output
   out_once_a: assert property ($changed(ZERO_CROSS_OUT) |=> $stable(ZERO_CROSS_OUT))
      else $error("detector output glitched");
endmodule // zcloi_checker

// ==== sim/zcloi_comp_model.sv ====
// Purpose: behavioural comparator watching the external ac waveform
// Assumes: wave_hi is 1 while the pin sits above the switching reference
// Notes: fixed analog delay, unrelated to the MCLK phase
module zcloi_comp_model
(
   // waveform side
   input wire logic wave_hi,
   // decision to the block
   output logic comp_sink
);
   timeunit 1ns;
   timeprecision 1ps;
   // above reference asks for sink; the pin pull-up is off, so nothing else pulls it
   initial comp_sink = 1'b0;
   always @(wave_hi) comp_sink <= #37 wave_hi;
endmodule // zcloi_comp_model
